//--- rtl/dir_pkg.sv
// Shared constants and types for the drive interrupt register block
package dir_pkg;
  localparam int DIR_ADDR_W = 16;
  localparam int DIR_DATA_W = 8;
  // Byte addresses of the registers
  localparam logic [15:0] DIR_UART_FLAGS_ADDR = 16'hFF78;
  localparam logic [15:0] DIR_UART_MASK_ADDR = 16'hFF79;
  localparam logic [15:0] DIR_FLAGS_A_ADDR = 16'hFF7A;
  localparam logic [15:0] DIR_MASK_A_ADDR = 16'hFF7B;
  localparam logic [15:0] DIR_FLAGS_B_ADDR = 16'hFF7C;
  localparam logic [15:0] DIR_MASK_B_ADDR = 16'hFF7D;
  localparam logic [15:0] DIR_HOST_FLAGS_ADDR = 16'hFF92;
  // Field positions
  localparam int DIR_A_BSUM_BIT = 0;
  localparam int DIR_B_ASUM_BIT = 1;
  localparam int DIR_B_USUM_BIT = 0;
  // Bits that a write may clear or enable
  localparam logic [7:0] DIR_A_CLR_MASK = 8'hFE;
  localparam logic [7:0] DIR_A_EN_MASK = 8'hFF;
  localparam logic [7:0] DIR_B_CLR_MASK = 8'hFC;
  localparam logic [7:0] DIR_B_EN_MASK = 8'hFC;
  localparam logic [7:0] DIR_U_CLR_MASK = 8'hFF;
  // Reset values
  localparam logic [7:0] DIR_FLAGS_RST = 8'h00;
  localparam logic [7:0] DIR_MASK_RST = 8'h00;
  localparam logic [7:0] DIR_RDATA_RST = 8'h00;
  // One register bus request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } dir_bus_req_type;
endpackage : dir_pkg

//--- rtl/dir_irq_regs.sv
// Drive, UART and host port interrupt status, clear and enable registers
//
// What this block does
// - Separate host irq from host flags register.
// - Drive irq gathers six drive and UART registers.
// - Two drive flag/mask pairs, one UART pair.
// - Clear single flags or several per write.
// - Group A flags layout, bit0 group B summary.
// - Group A write clears bits 7 to 1.
// - Writing one to A clear negates flag.
// - Group A mask write-only, all eight bits.
// - Mask one lets A flag report, interrupt.
// - Mask zero hides flag and its request.
// - Group B flags layout with two summaries.
// - Group B write clears bits 7 to 2.
// - Writing one to B clear negates flag.
// - Group B mask write-only, bits 7 to 2.
// - Mask one enables group B flag.
// - Host flags register holds eight host events.
// - A bit0 shows enabled group B pending.
// - B bit1 shows enabled group A pending.
// - B bit0 shows enabled UART pending.
// - Drive irq low when any group pending.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module dir_irq_regs
  import dir_pkg::*;
#(
  parameter int ADDR_W = dir_pkg::DIR_ADDR_W
)(
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Register bus
  input wire dir_pkg::dir_bus_req_type bus_i,
  output logic [7:0] rdata_o,
  // Hardware events, one-cycle pulses from same-clock logic
  input wire logic [7:1] drive_a_evt_i,
  input wire logic [7:2] drive_b_evt_i,
  input wire logic [7:0] uart_evt_i,
  // Host port event levels, owned and cleared by the host interface
  input wire logic [7:0] host_port_flags_i,
  // Interrupt pins to the sub-CPU, active low
  output logic host_irq_n_o,
  output logic drive_irq_out_n_o
);
  import dir_pkg::*;

  // The decoder compares full 16-bit byte addresses, so no other width works
  if (ADDR_W != DIR_ADDR_W)
  begin : g_addr_w_check
    $error("dir_irq_regs: ADDR_W must be 16");
  end

  logic [7:0] flags_a_reg;
  logic [7:0] flags_b_reg;
  logic [7:0] flags_u_reg;
  logic [7:0] mask_a_reg;
  logic [7:0] mask_b_reg;
  logic [7:0] mask_u_reg;
  logic [7:0] host_flags_reg;
  logic [7:0] flags_a_next;
  logic [7:0] flags_b_next;
  logic [7:0] flags_u_next;
  logic [7:0] rdata_next;
  logic [7:0] status_a;
  logic [7:0] status_b;
  logic pend_a;
  logic pend_b;
  logic pend_u;
  logic wr_a;
  logic wr_b;
  logic wr_u;

  // Sticky flag update; the event term is ORed last so it wins
  function automatic logic [7:0] flag_update(
    input logic [7:0] flags,
    input logic [7:0] evt,
    input logic clr,
    input logic [7:0] wdata,
    input logic [7:0] clr_mask
  );
    logic [7:0] kill;
    kill = clr ? (wdata & clr_mask) : 8'h00;
    return (flags & ~kill) | (evt & clr_mask);
  endfunction : flag_update

  function automatic logic hit(
    input dir_bus_req_type req,
    input logic [15:0] addr
  );
    return req.addr == addr;
  endfunction : hit

  assign wr_a = bus_i.wr && hit(bus_i, DIR_FLAGS_A_ADDR);
  assign wr_b = bus_i.wr && hit(bus_i, DIR_FLAGS_B_ADDR);
  assign wr_u = bus_i.wr && hit(bus_i, DIR_UART_FLAGS_ADDR);

  assign flags_a_next = flag_update(flags_a_reg, {drive_a_evt_i, 1'b0}, wr_a,
                                    bus_i.wdata, DIR_A_CLR_MASK);
  assign flags_b_next = flag_update(flags_b_reg, {drive_b_evt_i, 2'b00}, wr_b,
                                    bus_i.wdata, DIR_B_CLR_MASK);
  assign flags_u_next = flag_update(flags_u_reg, uart_evt_i, wr_u,
                                    bus_i.wdata, DIR_U_CLR_MASK);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flags_a_reg <= DIR_FLAGS_RST;
      flags_b_reg <= DIR_FLAGS_RST;
      flags_u_reg <= DIR_FLAGS_RST;
    end
    else if (ce_i)
    begin
      flags_a_reg <= flags_a_next;
      flags_b_reg <= flags_b_next;
      flags_u_reg <= flags_u_next;
    end
  end

  // Masks are write-only; reads of their addresses return zero
  // group A, group B and UART masks
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mask_a_reg <= DIR_MASK_RST;
      mask_b_reg <= DIR_MASK_RST;
      mask_u_reg <= DIR_MASK_RST;
    end
    else if (ce_i && bus_i.wr)
    begin
      if (hit(bus_i, DIR_MASK_A_ADDR))
      begin
        mask_a_reg <= bus_i.wdata & DIR_A_EN_MASK;
      end
      if (hit(bus_i, DIR_MASK_B_ADDR))
      begin
        mask_b_reg <= bus_i.wdata & DIR_B_EN_MASK;
      end
      if (hit(bus_i, DIR_UART_MASK_ADDR))
      begin
        mask_u_reg <= bus_i.wdata;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      host_flags_reg <= DIR_FLAGS_RST;
    end
    else if (ce_i)
    begin
      host_flags_reg <= host_port_flags_i;
    end
  end

  assign pend_a = |(flags_a_reg & mask_a_reg & DIR_A_CLR_MASK);
  assign pend_b = |(flags_b_reg & mask_b_reg & DIR_B_CLR_MASK);
  assign pend_u = |(flags_u_reg & mask_u_reg);

  always_comb
  begin
    status_a = flags_a_reg & mask_a_reg & DIR_A_CLR_MASK;
    status_a[DIR_A_BSUM_BIT] = pend_b & mask_a_reg[DIR_A_BSUM_BIT];
  end

  always_comb
  begin
    status_b = flags_b_reg & mask_b_reg & DIR_B_CLR_MASK;
    status_b[DIR_B_ASUM_BIT] = pend_a;
    status_b[DIR_B_USUM_BIT] = pend_u;
  end

  // Read data stand only in the cycle after the strobe
  always_comb
  begin
    rdata_next = 8'h00;
    if (bus_i.rd)
    begin
      unique case (bus_i.addr)
        DIR_FLAGS_A_ADDR: rdata_next = status_a;
        DIR_FLAGS_B_ADDR: rdata_next = status_b;
        DIR_UART_FLAGS_ADDR: rdata_next = flags_u_reg & mask_u_reg;
        DIR_HOST_FLAGS_ADDR: rdata_next = host_flags_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdata_o <= DIR_RDATA_RST;
    end
    else if (ce_i)
    begin
      rdata_o <= rdata_next;
    end
  end

  // Pins are registered to keep them glitch-free; one cycle behind flags
  // host pin from host flags only
  // drive pin from drive and UART
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      host_irq_n_o <= 1'b1;
      drive_irq_out_n_o <= 1'b1;
    end
    else if (ce_i)
    begin
      host_irq_n_o <= ~(|host_flags_reg);
      drive_irq_out_n_o <= ~(pend_a | pend_b | pend_u);
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_clear_a_flags: assert property (
    ce_i && wr_a && !(|({drive_a_evt_i, 1'b0} & bus_i.wdata))
    |=> (flags_a_reg & $past(bus_i.wdata) & DIR_A_CLR_MASK) == 8'h00)
    else $error("group A clear did not negate flags");

  chk_clear_b_flags: assert property (
    ce_i && wr_b && !(|({drive_b_evt_i, 2'b00} & bus_i.wdata))
    |=> (flags_b_reg & $past(bus_i.wdata) & DIR_B_CLR_MASK) == 8'h00)
    else $error("group B clear did not negate flags");

  chk_event_wins: assert property (
    ce_i && |drive_a_evt_i
    |=> (flags_a_reg[7:1] & $past(drive_a_evt_i)) == $past(drive_a_evt_i))
    else $error("group A event lost");

  chk_flags_sticky: assert property (
    ce_i && !wr_a && !wr_b
    |=> ((flags_a_reg & $past(flags_a_reg)) == $past(flags_a_reg))
        && ((flags_b_reg & $past(flags_b_reg)) == $past(flags_b_reg)))
    else $error("flag dropped without clear");

  chk_read_masked: assert property (
    ce_i && bus_i.rd && hit(bus_i, DIR_FLAGS_A_ADDR)
    |=> (rdata_o & ~$past(mask_a_reg)) == 8'h00)
    else $error("disabled group A flag reported");

  chk_summary_bits: assert property (
    status_b[DIR_B_ASUM_BIT] == pend_a && status_b[DIR_B_USUM_BIT] == pend_u
    && status_a[DIR_A_BSUM_BIT] == (pend_b && mask_a_reg[DIR_A_BSUM_BIT]))
    else $error("summary bit mismatch");

  chk_drive_pin: assert property (
    ce_i |=> drive_irq_out_n_o == !($past(pend_a) || $past(pend_b) || $past(pend_u)))
    else $error("drive irq pin wrong");

  chk_host_pin: assert property (
    ce_i |=> host_irq_n_o == !(|$past(host_flags_reg)))
    else $error("host irq pin wrong");

  chk_mask_b_unused: assert property (
    mask_b_reg[1:0] == 2'b00)
    else $error("unused group B mask bits set");

  chk_read_one_cycle: assert property (
    ce_i && !bus_i.rd |=> rdata_o == 8'h00)
    else $error("read data outside read slot");

  chk_reset_zero: assert property (@(posedge clk_i) disable iff (1'b0)
    $past(rst_i) |-> flags_a_reg == 8'h00 && mask_a_reg == 8'h00
    && flags_b_reg == 8'h00 && drive_irq_out_n_o)
    else $error("state not cleared by reset");

  chk_mask_a_write: assert property (
    ce_i && bus_i.wr && hit(bus_i, DIR_MASK_A_ADDR)
    |=> mask_a_reg == $past(bus_i.wdata))
    else $error("group A mask write lost");

  chk_mask_b_write: assert property (
    ce_i && bus_i.wr && hit(bus_i, DIR_MASK_B_ADDR)
    |=> mask_b_reg[7:2] == $past(bus_i.wdata[7:2]))
    else $error("group B mask write lost");

  chk_masks_held: assert property (
    ce_i && !bus_i.wr
    |=> $stable(mask_a_reg) && $stable(mask_b_reg) && $stable(mask_u_reg))
    else $error("mask changed without a write");

  chk_event_b_wins: assert property (
    ce_i && |drive_b_evt_i
    |=> (flags_b_reg[7:2] & $past(drive_b_evt_i)) == $past(drive_b_evt_i))
    else $error("group B event lost");

  chk_a_sum_kept: assert property (
    ce_i && wr_a && status_a[DIR_A_BSUM_BIT]
    |=> status_a[DIR_A_BSUM_BIT])
    else $error("group A write cleared the summary bit");

  chk_b_sums_kept: assert property (
    ce_i && wr_b && |status_b[1:0]
    |=> (status_b[1:0] & $past(status_b[1:0])) == $past(status_b[1:0]))
    else $error("group B write cleared a summary bit");

  chk_read_b_masked: assert property (
    ce_i && bus_i.rd && hit(bus_i, DIR_FLAGS_B_ADDR)
    |=> (rdata_o[7:2] & ~$past(mask_b_reg[7:2])) == 6'h00)
    else $error("disabled group B flag reported");

  chk_read_uart_masked: assert property (
    ce_i && bus_i.rd && hit(bus_i, DIR_UART_FLAGS_ADDR)
    |=> (rdata_o & ~$past(mask_u_reg)) == 8'h00)
    else $error("disabled UART flag reported");

  chk_read_host: assert property (
    ce_i && bus_i.rd && hit(bus_i, DIR_HOST_FLAGS_ADDR)
    |=> rdata_o == $past(host_flags_reg))
    else $error("host flags read wrong");

  chk_host_copy: assert property (
    ce_i |=> host_flags_reg == $past(host_port_flags_i))
    else $error("host flags not copied");

  chk_clear_uart: assert property (
    ce_i && wr_u && !(|(uart_evt_i & bus_i.wdata))
    |=> (flags_u_reg & $past(bus_i.wdata)) == 8'h00)
    else $error("UART clear did not negate flags");

  chk_uart_summary: assert property (
    ce_i && |(uart_evt_i & mask_u_reg) && !bus_i.wr
    |=> status_b[DIR_B_USUM_BIT])
    else $error("enabled UART event not summarised");

  chk_b_summary_in_a: assert property (
    ce_i && |({drive_b_evt_i, 2'b00} & mask_b_reg) && mask_a_reg[DIR_A_BSUM_BIT] && !bus_i.wr
    |=> status_a[DIR_A_BSUM_BIT])
    else $error("enabled group B event not summarised");

  chk_frozen_ce: assert property (
    !ce_i
    |=> $stable(flags_a_reg) && $stable(flags_b_reg) && $stable(flags_u_reg)
        && $stable(rdata_o) && $stable(drive_irq_out_n_o))
    else $error("state moved while clock enable low");

  cov_event_then_clear: cover property (
    ce_i && |drive_a_evt_i ##[1:20] ce_i && wr_a);
  cov_drive_irq: cover property ($fell(drive_irq_out_n_o));
  cov_event_clear_same: cover property (ce_i && wr_b && |drive_b_evt_i);
  cov_host_irq: cover property ($fell(host_irq_n_o));
  cov_uart_summary: cover property (status_b[DIR_B_USUM_BIT]);
endmodule : dir_irq_regs

//--- sim/dir_cpu_model.sv
// Sub-CPU model: byte register bus master
`timescale 1ns/1ps
module dir_cpu_model
  import dir_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Register bus
  output dir_pkg::dir_bus_req_type bus_o,
  input wire logic [7:0] rdata_i
);
  initial bus_o = '0;
  // One idle cycle after each strobe, so no strobe is set twice in one step
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus_o <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_i);
    bus_o <= '0;
    @(posedge clk_i);
  endtask : wr
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    bus_o <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_i);
    bus_o <= '0;
    @(posedge clk_i);
    d = rdata_i;
  endtask : rd
endmodule : dir_cpu_model

//--- sim/tb_top.sv
// Self-checking bench for the drive interrupt registers
`timescale 1ns/1ps
module tb_top;
  import dir_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  dir_bus_req_type bus;
  logic [7:0] rdata;
  logic [7:1] ev_a = 7'h00;
  logic [7:2] ev_b = 6'h00;
  logic [7:0] ev_u = 8'h00;
  logic [7:0] host = 8'h00;
  logic host_n;
  logic drv_n;
  int fails = 0;
  int comparisons = 0;

  always #2.5 clk_i = ~clk_i;

  dir_cpu_model cpu_u (.clk_i(clk_i), .bus_o(bus), .rdata_i(rdata));
  dir_irq_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .bus_i(bus),
    .rdata_o(rdata), .drive_a_evt_i(ev_a), .drive_b_evt_i(ev_b), .uart_evt_i(ev_u),
    .host_port_flags_i(host), .host_irq_n_o(host_n), .drive_irq_out_n_o(drv_n));

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic rchk(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    cpu_u.rd(a, d);
    chk($sformatf("reg %h", a), e, d);
  endtask : rchk

  // Pins are registered; look at the third edge so callers stay edge-aligned
  task automatic pins(input logic h, input logic d);
    repeat (3) @(posedge clk_i);
    chk("host pin", {7'h00, h}, {7'h00, host_n});
    chk("drive pin", {7'h00, d}, {7'h00, drv_n});
  endtask : pins

  task automatic pulse(input logic [7:1] a, input logic [7:2] b, input logic [7:0] u);
    ev_a <= a;
    ev_b <= b;
    ev_u <= u;
    @(posedge clk_i);
    ev_a <= 7'h00;
    ev_b <= 6'h00;
    ev_u <= 8'h00;
  endtask : pulse

  task automatic t_reset;
    rchk(DIR_FLAGS_A_ADDR, 8'h00);
    rchk(DIR_FLAGS_B_ADDR, 8'h00);
    rchk(DIR_UART_FLAGS_ADDR, 8'h00);
    rchk(DIR_MASK_A_ADDR, 8'h00);
    rchk(16'hFF7E, 8'h00);
    pins(1'b1, 1'b1);
  endtask : t_reset

  task automatic t_group_a;
    pulse(7'h55, 6'h00, 8'h00);
    rchk(DIR_FLAGS_A_ADDR, 8'h00);
    pins(1'b1, 1'b1);
    cpu_u.wr(DIR_MASK_A_ADDR, 8'hFF);
    rchk(DIR_FLAGS_A_ADDR, 8'hAA);
    rchk(DIR_FLAGS_B_ADDR, 8'h02);
    pins(1'b1, 1'b0);
    cpu_u.wr(DIR_FLAGS_A_ADDR, 8'h82);
    rchk(DIR_FLAGS_A_ADDR, 8'h28);
    cpu_u.wr(DIR_FLAGS_A_ADDR, 8'hFF);
    rchk(DIR_FLAGS_A_ADDR, 8'h00);
    pins(1'b1, 1'b1);
  endtask : t_group_a

  task automatic t_group_b;
    cpu_u.wr(DIR_MASK_B_ADDR, 8'hFF);
    pulse(7'h00, 6'h3F, 8'h00);
    rchk(DIR_FLAGS_B_ADDR, 8'hFC);
    rchk(DIR_FLAGS_A_ADDR, 8'h01);
    cpu_u.wr(DIR_FLAGS_A_ADDR, 8'hFF);
    rchk(DIR_FLAGS_A_ADDR, 8'h01);
    pins(1'b1, 1'b0);
    cpu_u.wr(DIR_FLAGS_B_ADDR, 8'h83);
    rchk(DIR_FLAGS_B_ADDR, 8'h7C);
    cpu_u.wr(DIR_MASK_B_ADDR, 8'h00);
    rchk(DIR_FLAGS_B_ADDR, 8'h00);
    pins(1'b1, 1'b1);
    cpu_u.wr(DIR_FLAGS_B_ADDR, 8'hFF);
    cpu_u.wr(DIR_MASK_B_ADDR, 8'hFF);
    rchk(DIR_FLAGS_B_ADDR, 8'h00);
  endtask : t_group_b

  task automatic t_uart;
    cpu_u.wr(DIR_UART_MASK_ADDR, 8'hFF);
    pulse(7'h00, 6'h00, 8'h81);
    rchk(DIR_UART_FLAGS_ADDR, 8'h81);
    rchk(DIR_FLAGS_B_ADDR, 8'h01);
    cpu_u.wr(DIR_FLAGS_B_ADDR, 8'hFF);
    rchk(DIR_FLAGS_B_ADDR, 8'h01);
    pins(1'b1, 1'b0);
    cpu_u.wr(DIR_UART_FLAGS_ADDR, 8'h81);
    rchk(DIR_FLAGS_B_ADDR, 8'h00);
    pins(1'b1, 1'b1);
  endtask : t_uart

  // Event and clear on the same edge; clear of another bit still acts
  task automatic t_race;
    pulse(7'h02, 6'h00, 8'h00);
    @(posedge clk_i);
    fork
      cpu_u.wr(DIR_FLAGS_A_ADDR, 8'h06);
      pulse(7'h01, 6'h00, 8'h00);
    join
    rchk(DIR_FLAGS_A_ADDR, 8'h02);
    cpu_u.wr(DIR_FLAGS_A_ADDR, 8'h02);
    rchk(DIR_FLAGS_A_ADDR, 8'h00);
  endtask : t_race

  task automatic t_host;
    host <= 8'h81;
    @(posedge clk_i);
    pins(1'b0, 1'b1);
    rchk(DIR_HOST_FLAGS_ADDR, 8'h81);
    host <= 8'h00;
    @(posedge clk_i);
    pins(1'b1, 1'b1);
  endtask : t_host

  // Clock enable low ignores events; a second reset clears the masks
  task automatic t_freeze;
    ce_i <= 1'b0;
    pulse(7'h40, 6'h00, 8'h00);
    ce_i <= 1'b1;
    rchk(DIR_FLAGS_A_ADDR, 8'h00);
    pulse(7'h40, 6'h00, 8'h00);
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(DIR_FLAGS_A_ADDR, 8'h00);
    pulse(7'h40, 6'h00, 8'h00);
    pins(1'b1, 1'b1);
    cpu_u.wr(DIR_MASK_A_ADDR, 8'hFF);
    rchk(DIR_FLAGS_A_ADDR, 8'h80);
    cpu_u.wr(DIR_FLAGS_A_ADDR, 8'h80);
    rchk(DIR_FLAGS_A_ADDR, 8'h00);
  endtask : t_freeze

  task automatic test_done;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done

  // Watchdog: a hang counts as a mismatch
  initial
  begin
    #100000;
    fails++;
    test_done;
  end

  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_group_a;
    t_group_b;
    t_uart;
    t_race;
    t_host;
    t_freeze;
    test_done;
  end
endmodule : tb_top
